//--- hdl/sbm_unit.v
// Purpose: datapath for single-bit test, invert, clear and set, plus carry and direction flag ops
// Assumes: bus answers each transfer with one-cycle mem_ack_in, same clock domain
// Notes:   flags are held here; undefined flags are left at their previous value
//
// What this block does
// - Bit test sets the zero flag when the selected bit is 0 and clears it when 1, 16-bit immediates use low 4 bits.
// - Bit test on 16-bit memory with immediate uses low 4 bits, one read and no write.
// - Bit invert on 8-bit operands flips only the bit picked by the low 3 count bits, flags kept.
// - Bit invert on 16-bit operands picks the bit with the low 4 count bits.
// - Invert, clear and set on memory do one read then one write.
// - Bit invert on an 8-bit register with a 3-bit immediate uses the low 3 bits of that byte.
// - Bit invert with a 4-bit immediate on 16-bit operands uses the low 4 immediate bits.
// - Carry invert complements the carry flag, other flags undefined.
// - Bit clear on 8-bit operands zeroes the bit picked by the low 3 count bits, flags kept.
// - Bit clear on 16-bit operands picks the bit with the low 4 count bits.
// - Bit clear with a 3-bit immediate on 8-bit operands uses the low 3 immediate bits.
// - Bit clear with a 4-bit immediate on 16-bit operands uses the low 4 immediate bits.
// - Direction clear forces the direction flag to 0 so block ops increment the indexes.
// - Bit set on 8-bit operands forces to 1 the bit picked by the low 3 count bits, flags kept.
`timescale 1ns/10ps
`include "sbm_map.vh"

module sbm_unit (
    input  wire        sys_clk_in,
    input  wire        rst_n_in,
    input  wire        start_in,
    input  wire [2:0]  op_in,
    input  wire        word_in,
    input  wire        mem_in,
    input  wire        use_imm_in,
    input  wire [7:0]  count_low_reg_in,
    input  wire [7:0]  imm_in,
    input  wire [15:0] reg_operand_in,
    input  wire [15:0] mem_addr_in,
    output wire        busy_out,
    output reg         done_out,
    output reg  [15:0] result_out,
    output reg         result_we_out,
    output reg         mem_req_out,
    output reg         mem_wr_out,
    output reg         mem_word_out,
    output reg  [15:0] mem_addr_out,
    output reg  [15:0] mem_wdata_out,
    input  wire [15:0] mem_rdata_in,
    input  wire        mem_ack_in,
    output reg         zero_flag_out,
    output reg         overflow_flag_out,
    output reg         carry_flag_out,
    output reg         direction_flag_out,
    output reg  [1:0]  xfer_count_out
);

    localparam ST_IDLE  = 2'h0;
    localparam ST_READ  = 2'h1;
    localparam ST_WRITE = 2'h2;

    reg [1:0]  state_reg;
    reg [2:0]  op_reg;
    reg        word_reg;
    reg [3:0]  idx_reg;

    // Next values, one per register, settled by the decode process below
    reg [1:0]  state_next;
    reg [2:0]  op_next;
    reg        word_next;
    reg [3:0]  idx_next;
    reg        done_next;
    reg [15:0] result_next;
    reg        result_we_next;
    reg        mem_req_next;
    reg        mem_wr_next;
    reg        mem_word_next;
    reg [15:0] mem_addr_next;
    reg [15:0] mem_wdata_next;
    reg        zero_next;
    reg        overflow_next;
    reg        carry_next;
    reg        direction_next;
    reg [1:0]  xfer_next;

    // Bit position: 3 bits for bytes, 4 for words, from count register or immediate
    function [3:0] sel_index;
        input       wide;
        input [7:0] src;
        begin
            if (wide)
                sel_index = src[`SBM_IDX16_W-1:0];
            else
                sel_index = {1'b0, src[`SBM_IDX8_W-1:0]};
        end
    endfunction

    // Apply the bit operation; test leaves the operand alone
    function [15:0] bit_apply;
        input [2:0]  op;
        input [15:0] val;
        input [3:0]  idx;
        reg   [15:0] mask;
        begin
            mask = 16'h0001 << idx;
            case (op)
                `SBM_OP_INVERT: bit_apply = val ^ mask;
                `SBM_OP_CLEAR:  bit_apply = val & ~mask;
                `SBM_OP_SET:    bit_apply = val | mask;
                default:        bit_apply = val;
            endcase
        end
    endfunction

    // Byte operands ignore the upper half so a stray high byte never matters
    function tested_zero;
        input        wide;
        input [15:0] val;
        input [3:0]  idx;
        reg   [15:0] v;
        begin
            v = wide ? val : {8'h00, val[7:0]};
            tested_zero = ~v[idx];
        end
    endfunction

    wire [3:0] idx_now = sel_index(word_in, use_imm_in ? imm_in : count_low_reg_in);
    wire       is_bit_op = (op_in <= `SBM_OP_SET);

    // Modified operands: register path uses live inputs, memory path the latched op
    wire [15:0] reg_value = bit_apply(op_in, reg_operand_in, idx_now);
    wire [15:0] rmw_value = bit_apply(op_reg, mem_rdata_in, idx_reg);

    // Operation classes of the latched op, for readability of the read branch
    wire       held_is_test = (op_reg == `SBM_OP_TEST);

    // Busy only while a bus transfer is pending; register ops never look busy
    assign busy_out = (state_reg != ST_IDLE);

    // Decode: values hold unless a branch below moves them; done and result write enable default to 0
    always @* begin
        state_next     = state_reg;
        op_next        = op_reg;
        word_next      = word_reg;
        idx_next       = idx_reg;
        done_next      = 1'b0;
        result_next    = result_out;
        result_we_next = 1'b0;
        mem_req_next   = mem_req_out;
        mem_wr_next    = mem_wr_out;
        mem_word_next  = mem_word_out;
        mem_addr_next  = mem_addr_out;
        mem_wdata_next = mem_wdata_out;
        zero_next      = zero_flag_out;
        overflow_next  = overflow_flag_out;
        carry_next     = carry_flag_out;
        direction_next = direction_flag_out;
        xfer_next      = xfer_count_out;
        case (state_reg)
            ST_IDLE: begin
                if (start_in) begin
                    // Latch the op so later input changes cannot disturb a bus op
                    op_next   = op_in;
                    word_next = word_in;
                    idx_next  = idx_now;
                    xfer_next = 2'h0;
                    if (is_bit_op && mem_in) begin
                        // Memory operand: one read first
                        state_next    = ST_READ;
                        mem_req_next  = 1'b1;
                        mem_wr_next   = 1'b0;
                        mem_word_next = word_in;
                        mem_addr_next = mem_addr_in;
                    end else begin
                        // Register and flag ops finish in one cycle
                        done_next = 1'b1;
                        case (op_in)
                            `SBM_OP_TEST: begin
                                zero_next     = tested_zero(word_in, reg_operand_in, idx_now);
                                overflow_next = 1'b0;
                                carry_next    = 1'b0;
                            end
                            `SBM_OP_INVERT, `SBM_OP_CLEAR, `SBM_OP_SET: begin
                                // Flags untouched by the modify ops
                                result_next    = reg_value;
                                result_we_next = 1'b1;
                            end
                            `SBM_OP_CY_INVERT: carry_next     = ~carry_flag_out;
                            `SBM_OP_CY_CLEAR:  carry_next     = 1'b0;
                            `SBM_OP_DIR_CLEAR: direction_next = 1'b0;
                            default: ;
                        endcase
                    end
                end
            end
            ST_READ: begin
                if (mem_ack_in) begin
                    xfer_next = `SBM_XFER_TEST;
                    if (held_is_test) begin
                        // Test reads once and never writes back
                        mem_req_next  = 1'b0;
                        state_next    = ST_IDLE;
                        done_next     = 1'b1;
                        zero_next     = tested_zero(word_reg, mem_rdata_in, idx_reg);
                        overflow_next = 1'b0;
                        carry_next    = 1'b0;
                    end else begin
                        // Modified value goes back to the same address
                        mem_wr_next    = 1'b1;
                        mem_wdata_next = rmw_value;
                        result_next    = rmw_value;
                        state_next     = ST_WRITE;
                    end
                end
            end
            ST_WRITE: begin
                if (mem_ack_in) begin
                    // Second transfer done, release the bus
                    xfer_next    = `SBM_XFER_RMW;
                    mem_req_next = 1'b0;
                    mem_wr_next  = 1'b0;
                    state_next   = ST_IDLE;
                    done_next    = 1'b1;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Sequencer state and latched operation
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg      <= ST_IDLE;
            op_reg         <= 3'h0;
            word_reg       <= 1'b0;
            idx_reg        <= 4'h0;
            xfer_count_out <= 2'h0;
        end else begin
            state_reg      <= state_next;
            op_reg         <= op_next;
            word_reg       <= word_next;
            idx_reg        <= idx_next;
            xfer_count_out <= xfer_next;
        end
    end

    // Bus request outputs, held stable through each transfer
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mem_req_out   <= 1'b0;
            mem_wr_out    <= 1'b0;
            mem_word_out  <= 1'b0;
            mem_addr_out  <= 16'h0000;
            mem_wdata_out <= 16'h0000;
        end else begin
            mem_req_out   <= mem_req_next;
            mem_wr_out    <= mem_wr_next;
            mem_word_out  <= mem_word_next;
            mem_addr_out  <= mem_addr_next;
            mem_wdata_out <= mem_wdata_next;
        end
    end

    // Completion pulse and result word
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_out      <= 1'b0;
            result_out    <= 16'h0000;
            result_we_out <= 1'b0;
        end else begin
            done_out      <= done_next;
            result_out    <= result_next;
            result_we_out <= result_we_next;
        end
    end

    // Flags; undefined ones simply keep their value, cheaper than faking them
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            zero_flag_out      <= `SBM_FLAG_RST;
            overflow_flag_out  <= `SBM_FLAG_RST;
            carry_flag_out     <= `SBM_FLAG_RST;
            direction_flag_out <= `SBM_FLAG_RST;
        end else begin
            zero_flag_out      <= zero_next;
            overflow_flag_out  <= overflow_next;
            carry_flag_out     <= carry_next;
            direction_flag_out <= direction_next;
        end
    end

endmodule // sbm_unit

//--- hdl/sbm_map.vh
// Purpose: constants for the single-bit manipulation unit
// Assumes: included by sbm_unit.v only
// Notes:   opcodes are this block's own encoding
`ifndef SBM_MAP_VH
`define SBM_MAP_VH
// Operation codes on op_in
`define SBM_OP_TEST      3'h0
`define SBM_OP_INVERT    3'h1
`define SBM_OP_CLEAR     3'h2
`define SBM_OP_SET       3'h3
`define SBM_OP_CY_INVERT 3'h4
`define SBM_OP_CY_CLEAR  3'h5
`define SBM_OP_DIR_CLEAR 3'h6
// Index field widths
`define SBM_IDX8_W       3
`define SBM_IDX16_W      4
// Bus transfer counts
`define SBM_XFER_TEST    2'h1
`define SBM_XFER_RMW     2'h2
// Flag reset values
`define SBM_FLAG_RST     1'h0
`endif

//--- tb/sbm_unit_sva.sv
// Purpose: port checks for sbm_unit
// Assumes: bound onto sbm_unit, one clock
// Notes: bit index is masked to the operand width here
`timescale 1ns/10ps
module sbm_unit_sva (
    input wire sys_clk_in, rst_n_in, start_in, word_in, mem_in, use_imm_in, busy_out, done_out,
    input wire result_we_out, mem_req_out, mem_wr_out, mem_word_out, mem_ack_in, zero_flag_out,
    input wire overflow_flag_out, carry_flag_out, direction_flag_out,
    input wire [2:0] op_in,
    input wire [1:0] xfer_count_out,
    input wire [7:0] count_low_reg_in, imm_in,
    input wire [15:0] reg_operand_in, mem_addr_in, mem_addr_out, result_out
);
    // Selected bit, width mask and expected register value
    wire [3:0] idx = (use_imm_in ? imm_in[3:0] : count_low_reg_in[3:0]) & (word_in ? 4'hf : 4'h7);
    wire [15:0] bm = 16'h1 << idx;
    wire [15:0] wm = word_in ? 16'hffff : 16'h00ff;
    wire [15:0] ex = op_in == 3'h1 ? reg_operand_in ^ bm : op_in == 3'h2 ? reg_operand_in & ~bm : reg_operand_in | bm;
    wire go = start_in && !busy_out;
    wire rg = go && !mem_in;
    wire bo = op_in != 3'h0 && op_in < 3'h4;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_rd_ack;
        mem_req_out && !mem_wr_out && mem_ack_in;
    endsequence
    chk_test_zero: assert property (rg && op_in == 3'h0 |=> zero_flag_out == !$past(reg_operand_in[idx]))
        else $error("zero flag");
    chk_test_vc: assert property (rg && op_in == 3'h0 |=> !overflow_flag_out && !carry_flag_out)
        else $error("V or CY");
    chk_reg_result: assert property (rg && bo |=> result_we_out && (result_out & $past(wm)) == $past(ex & wm))
        else $error("result");
    chk_flags_kept: assert property (rg && bo |=> $stable(carry_flag_out) && $stable(zero_flag_out))
        else $error("flags moved");
    chk_cy_invert: assert property (go && op_in == 3'h4 |=> carry_flag_out != $past(carry_flag_out))
        else $error("CY invert");
    chk_cy_clear: assert property (go && op_in == 3'h5 |=> !carry_flag_out)
        else $error("CY clear");
    chk_dir_clear: assert property (go && op_in == 3'h6 |=> !direction_flag_out)
        else $error("DIR clear");
    chk_mem_read: assert property (go && mem_in && op_in < 3'h4 |=> mem_req_out && !mem_wr_out
        && mem_addr_out == $past(mem_addr_in) && mem_word_out == $past(word_in))
        else $error("read start");
    chk_busy_req: assert property (mem_req_out |-> busy_out && !done_out)
        else $error("busy low");
    chk_wr_addr: assert property (s_rd_ack ##1 mem_req_out |-> mem_wr_out && $stable(mem_addr_out))
        else $error("write addr");
    chk_xfer_end: assert property ($fell(mem_req_out) |-> done_out && xfer_count_out == ($past(mem_wr_out) ? 2'h2 : 2'h1))
        else $error("xfer count");
endmodule // sbm_unit_sva

//--- tb/sbm_mem_model.sv
// Purpose: memory on the far side of the unit's bus
// Assumes: one transfer at a time, acked after lat_in waits
// Notes: read data toggles outside the ack cycle so stale data never matches
`timescale 1ns/10ps
module sbm_mem_model (
    input  wire logic clk_in, req_in, wr_in, word_in,
    input  wire logic [15:0] addr_in, wdata_in,
    input  wire logic [3:0] lat_in,
    output logic [15:0] rdata_out,
    output logic ack_out
);
    logic [15:0] mem [0:15];
    logic [3:0] wait_reg = 4'h0;
    initial ack_out = 1'h0;
    initial rdata_out = 16'h0;
    // Skip the cycle after an ack so one transfer gets one ack
    always @(posedge clk_in) begin
        ack_out <= 1'h0;
        rdata_out <= ~rdata_out;
        if (req_in && !ack_out && wait_reg == lat_in) begin
            ack_out <= 1'h1;
            wait_reg <= 4'h0;
            rdata_out <= mem[addr_in[3:0]];
            if (wr_in) mem[addr_in[3:0]] <= word_in ? wdata_in : {mem[addr_in[3:0]][15:8], wdata_in[7:0]};
        end else if (req_in && !ack_out) wait_reg <= wait_reg + 4'h1;
    end
endmodule // sbm_mem_model

//--- tb/sbm_unit_tb_top.sv
// Purpose: self-checking bench for sbm_unit
// Assumes: inputs change 1 ns after the rising edge
// Notes: unused index source carries the inverted index
`timescale 1ns/10ps
module sbm_unit_tb_top;
    logic sys_clk_in, rst_n_in, start_in, word_in, mem_in, use_imm_in, mem_ack_in, busy_out, done_out;
    logic result_we_out, mem_req_out, mem_wr_out, mem_word_out, zero_flag_out, overflow_flag_out;
    logic carry_flag_out, direction_flag_out;
    logic [2:0] op_in;
    logic [1:0] xfer_count_out;
    logic [3:0] lat;
    logic [7:0] count_low_reg_in, imm_in;
    logic [15:0] reg_operand_in, mem_addr_in, mem_rdata_in, result_out, mem_addr_out, mem_wdata_out, d, e;
    integer fails = 0, tests_run = 0, acks = 0, wrs = 0, o, w, k;
    sbm_unit u_dut (.*);
    sbm_mem_model u_mem (.clk_in(sys_clk_in), .req_in(mem_req_out), .wr_in(mem_wr_out), .word_in(mem_word_out),
        .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .lat_in(lat), .rdata_out(mem_rdata_in), .ack_out(mem_ack_in));
    initial begin
        sys_clk_in = 1'h0;
        forever #4 sys_clk_in = ~sys_clk_in;
    end
    // Count bus transfers and writes of each op
    always @(posedge sys_clk_in) if (mem_ack_in === 1'h1) begin
        acks <= acks + 1;
        wrs <= wrs + mem_wr_out;
    end
    task stop_test;
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task ck(input logic ok);
        tests_run = tests_run + 1;
        if (ok !== 1'h1) begin
            fails = fails + 1;
            $display("ERROR at %0t: mismatch", $time);
        end
    endtask
    function logic [15:0] ex(input integer o, w, input logic [15:0] d, input logic [3:0] k);
        logic [15:0] m;
        m = 16'h1 << (w ? k : k & 4'h7);
        ex = o == 1 ? d ^ m : o == 2 ? d & ~m : o == 3 ? d | m : d;
        if (w == 0) ex[15:8] = d[15:8];
    endfunction
    // One op from start to done, done wait bounded
    task go(input integer o, w, m, u, input logic [3:0] k, input logic [15:0] r);
        integer n;
        {op_in, word_in, mem_in, use_imm_in, reg_operand_in} = {o[2:0], w[0], m[0], u[0], r};
        count_low_reg_in = {4'hb, u[0] ? ~k : k};
        imm_in = {4'h6, u[0] ? k : ~k};
        {start_in, acks, wrs, n} = {1'h1, 96'h0};
        @(posedge sys_clk_in) #1 start_in = 1'h0;
        while (done_out !== 1'h1 && n < 40) @(posedge sys_clk_in) #1 n = n + 1;
        if (n == 40) ck(1'h0);
    endtask
    task t_flags;
        go(4, 0, 0, 0, 4'h0, 16'h0); ck(carry_flag_out === 1'h1);
        go(4, 0, 0, 0, 4'h0, 16'h0); ck(carry_flag_out === 1'h0);
        go(4, 0, 0, 0, 4'h0, 16'h0); go(5, 0, 0, 0, 4'h0, 16'h0); ck(carry_flag_out === 1'h0);
        go(6, 0, 0, 0, 4'h0, 16'h0); ck(direction_flag_out === 1'h0);
        go(4, 0, 0, 0, 4'h0, 16'h0);
    endtask
    task t_reg;
        for (o = 0; o < 4; o++) for (w = 0; w < 2; w++) for (k = 0; k < 16; k++) begin
            d = 16'h5a3c ^ (16'h1 << k);
            go(o, w, 0, k % 2, k[3:0], d);
            if (o == 0) ck(zero_flag_out === ~d[w ? k : k % 8] && {overflow_flag_out, carry_flag_out} === 2'h0);
            else ck(result_we_out === 1'h1 && (result_out & (w ? 16'hffff : 16'h00ff)) === ex(o, w, d, k) % (w ? 17'h10000 : 17'h100));
        end
    endtask
    task t_mem;
        for (o = 0; o < 4; o++) for (w = 0; w < 2; w++) begin
            {lat, mem_addr_in, d} = {o[0], 1'h0, w[0], 1'h0, 16'(o * 2 + w), o[0] ? 16'he385 : 16'hc3a5};
            u_mem.mem[o * 2 + w] = d;
            go(o, w, 1, o / 2, 4'hd, 16'h0);
            if (o != 0) ck(((result_out ^ ex(o, w, d, 4'hd)) & (w ? 16'hffff : 16'h00ff)) === 16'h0);
            ck(acks === (o ? 2 : 1) && wrs === (o ? 1 : 0) && xfer_count_out === (o ? 2'h2 : 2'h1));
            ck(u_mem.mem[o * 2 + w] === ex(o, w, d, 4'hd));
            if (o == 0) ck(zero_flag_out === ~d[w ? 13 : 5]);
        end
    endtask
    initial begin
        {rst_n_in, start_in, op_in, word_in, mem_in, use_imm_in, lat} = 12'h0;
        {count_low_reg_in, imm_in, reg_operand_in, mem_addr_in} = 48'h0;
        repeat (10) @(posedge sys_clk_in);
        #1 rst_n_in = 1'h1;
        t_flags;
        t_reg;
        t_mem;
        stop_test;
    end
    // Watchdog well past the few hundred cycles the run needs
    initial begin
        #100000;
        fails = fails + 1;
        stop_test;
    end
endmodule // sbm_unit_tb_top
bind sbm_unit sbm_unit_sva u_sva (.*);
